// file: src/smon_pkg.sv
`default_nettype none
package smon_pkg;
  // ********************************************************
  // word format
  // ********************************************************
  localparam int WORD_BITS = 16;
  localparam int CMD_RW_BIT = 15;
  localparam int CMD_OFS_MSB = 14;
  localparam int CMD_OFS_LSB = 5;
  localparam int CMD_CNT_MSB = 4;
  localparam logic [15:0] RECOVER_CMD = 16'hba61;
  localparam logic [12:0] DIAG_PATTERN = 13'h1555;
  // ********************************************************
  // fault register
  // ********************************************************
  localparam logic [9:0] FAULT_REG_OFS = 10'h01d3;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam int BIT_CKSYS = 2;
  localparam int BIT_FRAME = 1;
  localparam int BIT_WORD = 0;
  localparam logic [2:0] SEL_CFG = 3'h4;
  localparam logic [15:0] ARB_REPLY = 16'h0000;
  // ********************************************************
  // timing
  // ********************************************************
  localparam int CORE_PERIOD_PS = 10000;
  localparam int CKSYS_PERIOD_PS = 10000;
  localparam int SCLK_MIN_PCT = 125;
  localparam int SCLK_MIN_PS = CKSYS_PERIOD_PS * SCLK_MIN_PCT / 100;
  localparam int SCLK_MIN_CYC =
    (SCLK_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
  localparam int CS_GUARD_SCLK = 1;
  localparam logic [4:0] CS_GUARD_CYC = 5'(2 * CS_GUARD_SCLK * 8);
  localparam int WDOG_SHIFT = 4;
endpackage : smon_pkg
`default_nettype wire

// file: src/smon_link_if.sv
`default_nettype none
interface smon_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : smon_link_if
`default_nettype wire

// file: src/smon_host.sv
`default_nettype none
module smon_host (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // serial link
  smon_link_if.host link,
  // user side
  input wire logic i_req,
  input wire logic [15:0] i_word,
  input wire logic i_recover,
  input wire logic i_last,
  output logic o_ready,
  output logic o_rx_valid,
  output logic [15:0] o_rx_word
);
  typedef enum logic [4:0] {
    SH_IDLE = 5'b00001,
    SH_SETUP = 5'b00010,
    SH_SHIFT = 5'b00100,
    SH_WAIT = 5'b01000,
    SH_HOLD = 5'b10000
  } smon_hst_t;

  typedef struct packed {
    smon_hst_t st;
    logic [1:0] miso_s;
    logic sclk;
    logic cs_n;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [4:0] bits;
    logic [4:0] cnt;
    logic last;
    logic rx_valid;
  } smon_hs_t;

  smon_hs_t r, n;

  // ********************************************************
  // sequencing
  // ********************************************************
  always_comb
  begin
    n = r;
    n.rx_valid = 1'b0;
    n.miso_s = {r.miso_s[0], link.miso};
    case (r.st)
      SH_IDLE, SH_WAIT:
      begin
        if (i_req)
        begin
          // recovery must carry the exact code word
          n.tx = i_recover ? smon_pkg::RECOVER_CMD : i_word;
          n.last = i_last;
          n.cs_n = 1'b0;
          n.cnt = smon_pkg::CS_GUARD_CYC;
          n.st = (r.st == SH_IDLE) ? SH_SETUP : SH_SHIFT;
          if (r.st == SH_WAIT)
          begin
            n.cnt = 5'(smon_pkg::SCLK_HALF_CYC);
          end
        end
      end
      SH_SETUP:
      begin
        n.cnt = r.cnt - 5'd1;
        if (r.cnt == 5'd1)
        begin
          n.st = SH_SHIFT;
          n.cnt = 5'(smon_pkg::SCLK_HALF_CYC);
        end
      end
      SH_SHIFT:
      begin
        n.cnt = r.cnt - 5'd1;
        if (r.cnt == 5'd1)
        begin
          n.cnt = 5'(smon_pkg::SCLK_HALF_CYC);
          n.sclk = ~r.sclk;
          if (!r.sclk)
          begin
            n.rx = {r.rx[14:0], r.miso_s[1]};
          end
          else
          begin
            n.tx = {r.tx[14:0], 1'b0};
            n.bits = r.bits + 5'd1;
            if (r.bits == 5'd15)
            begin
              n.bits = 5'd0;
              n.rx_valid = 1'b1;
              // select stays low between words and rises only after the last word
              n.st = r.last ? SH_HOLD : SH_WAIT;
              n.cnt = smon_pkg::CS_GUARD_CYC;
            end
          end
        end
      end
      SH_HOLD:
      begin
        n.cnt = r.cnt - 5'd1;
        if (r.cnt == 5'd1)
        begin
          n.cs_n = 1'b1;
          n.st = SH_IDLE;
        end
      end
      default:
      begin
        n.st = SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      r <= '{st: SH_IDLE, miso_s: 2'b00, sclk: 1'b0, cs_n: 1'b1,
             tx: 16'h0000, rx: 16'h0000, bits: 5'd0, cnt: 5'd0,
             last: 1'b0, rx_valid: 1'b0};
    end
    else
    begin
      r <= n;
    end
  end

  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.tx[15];
  assign o_ready = (r.st == SH_IDLE) || (r.st == SH_WAIT);
  assign o_rx_valid = r.rx_valid;
  assign o_rx_word = r.rx;
endmodule : smon_host
`default_nettype wire

// file: src/smon_dev.sv
`default_nettype none
// Overview of operation
// - master keeps serial clock period at least 125%
// - select leads first edge, trails last edge
// - read-only three-bit fault register, reset zero
// - watch word and bit protocol, record faults
// - write words return pattern plus fault bits
// - first recorded fault freezes the register
// - enabled fault raises interrupt request
// - error state accepts only recovery read command
// - recovery sends one word, exits, drops interrupt
// - config target: reply fault code, clear register
// - other target: arbitrary reply, register kept
// - select low without system clock is fault
// - wrong burst length raises frame fault
// - gap timeout aborts transfer, frame fault
// - select framing wrong word count, frame fault
// - wrong bit count in word raises fault
// - bit fault reported at end of select
// - fault register reads zero when fault-free
// - gap limit comes from timeout setting
// - select framing zero count: no count fault
// - command: rw msb, ten-bit offset, five-bit count
module smon_dev (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // serial link
  smon_link_if.dev link,
  // configuration
  input wire logic i_cksys_ok,
  input wire logic i_mode_gap,
  input wire logic i_irq_en,
  input wire logic [7:0] i_wdog_limit,
  input wire logic [2:0] i_target_sel,
  // register access
  output logic o_wr_stb,
  output logic [9:0] o_wr_addr,
  output logic [15:0] o_wr_data,
  output logic o_rd_stb,
  output logic [9:0] o_rd_addr,
  input wire logic [15:0] i_rd_data,
  // status
  output logic [2:0] o_fault_flags,
  output logic o_error_state,
  output logic o_irq
);
  typedef enum logic [2:0] {
    SD_CMD = 3'b001,
    SD_DATA = 3'b010,
    SD_ERR = 3'b100
  } smon_dst_t;

  typedef struct packed {
    smon_dst_t st;
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    logic [1:0] cko_s;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [3:0] bits;
    logic [4:0] count;
    logic [4:0] words;
    logic [9:0] addr;
    logic rd;
    logic load;
    logic reply;
    logic [2:0] flags;
    logic [2:0] sel_f;
    logic irq;
    logic [11:0] idle;
    logic wr_stb;
    logic [9:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_stb;
  } smon_ds_t;

  smon_ds_t r, n;

  function automatic logic [15:0] diag_word(input logic [2:0] f);
    diag_word = {smon_pkg::DIAG_PATTERN, f};
  endfunction : diag_word

  logic rise;
  logic fall;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic word_done;
  logic [15:0] w;
  logic [2:0] fault;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb
  begin
    n = r;
    n.wr_stb = 1'b0;
    n.rd_stb = 1'b0;
    n.load = 1'b0;
    // first flop of each synchroniser feeds only the second
    n.sclk_s = {r.sclk_s[1:0], link.sclk};
    n.cs_s = {r.cs_s[1:0], link.cs_n};
    n.mosi_s = {r.mosi_s[0], link.mosi};
    n.cko_s = {r.cko_s[0], i_cksys_ok};
    rise = r.sclk_s[1] & ~r.sclk_s[2];
    fall = ~r.sclk_s[1] & r.sclk_s[2];
    cs_low = ~r.cs_s[1];
    cs_fall = ~r.cs_s[1] & r.cs_s[2];
    cs_rise = r.cs_s[1] & ~r.cs_s[2];
    w = {r.rx[14:0], r.mosi_s[1]};
    word_done = cs_low && rise && (r.bits == 4'hf);
    fault = 3'b000;
    if (cs_low && !r.cko_s[1])
      fault[smon_pkg::BIT_CKSYS] = 1'b1;

    if (cs_fall)
    begin
      n.bits = 4'h0;
      n.load = 1'b1;
      if (!i_mode_gap && r.st != SD_ERR)
        n.st = SD_CMD;
    end
    if (cs_low && rise)
    begin
      n.rx = w;
      n.bits = r.bits + 4'h1;
    end

    // no shift right after a word ends, the fresh word must hold
    if (cs_low && fall && r.bits != 4'h0)
      n.tx = {r.tx[14:0], 1'b0};
    if (word_done)
    begin
      n.load = 1'b1;
      case (r.st)
        SD_CMD:
        begin
          n.rd = w[smon_pkg::CMD_RW_BIT];
          n.addr = w[smon_pkg::CMD_OFS_MSB:smon_pkg::CMD_OFS_LSB];
          n.count = w[smon_pkg::CMD_CNT_MSB:0];
          n.words = 5'd0;
          n.idle = 12'h000;
          n.st = (i_mode_gap && w[4:0] == 5'd0) ? SD_CMD : SD_DATA;
        end
        SD_DATA:
        begin
          n.words = r.words + 5'd1;
          n.addr = r.addr + 10'h001;
          if (!r.rd)
          begin
            n.wr_stb = 1'b1;
            n.wr_addr = r.addr;
            n.wr_data = w;
          end
          if (r.count != 5'd0 && r.words == r.count)
            fault[smon_pkg::BIT_FRAME] = 1'b1;
          if (i_mode_gap && r.words + 5'd1 == r.count)
            n.st = SD_CMD;
        end
        SD_ERR:
        begin
          if (r.reply)
          begin
            n.st = SD_CMD;
            n.reply = 1'b0;
            n.irq = 1'b0;
          end
          else if (w == smon_pkg::RECOVER_CMD)
            n.reply = 1'b1;
        end
        default: n.st = SD_CMD;
      endcase
    end

    if (cs_rise)
    begin
      // a streamed burst only shows this once select returns
      if (r.bits != 4'h0)
        fault[smon_pkg::BIT_WORD] = 1'b1;
      if (!i_mode_gap && r.st == SD_DATA)
      begin
        // zero count: burst ends with select, nothing to compare
        if (r.count != 5'd0 && r.words != r.count)
          fault[smon_pkg::BIT_FRAME] = 1'b1;
        n.st = SD_CMD;
      end
    end

    if (i_mode_gap && r.st == SD_DATA)
    begin
      n.idle = (cs_low && rise) ? 12'h000 : r.idle + 12'h001;
      if (r.idle >= {i_wdog_limit, 4'h0})
      begin
        fault[smon_pkg::BIT_FRAME] = 1'b1;
        n.idle = 12'h000;
      end
    end

    // reply for the word that starts next, a cycle after its cause
    if (r.load)
    begin
      n.tx = diag_word(r.flags);
      if (r.st == SD_ERR && r.reply)
      begin
        if (r.sel_f == smon_pkg::SEL_CFG)
        begin
          n.tx = {13'h0000, r.flags};
          n.flags = smon_pkg::FLAGS_RST;
        end
        else
          n.tx = smon_pkg::ARB_REPLY;
      end
      // no fetch past the count: a read may clear what it reads
      else if (r.st == SD_DATA && r.rd &&
               (r.count == 5'd0 || r.words != r.count))
      begin
        n.rd_stb = 1'b1;
        n.tx = i_rd_data;
        if (r.addr == smon_pkg::FAULT_REG_OFS)
        begin
          n.tx = {13'h0000, r.flags};
          n.flags = smon_pkg::FLAGS_RST;
        end
      end
    end

    // later faults are dropped while one is latched; set beats clear
    if (fault != 3'b000 && n.flags == 3'b000 && r.st != SD_ERR)
    begin
      n.flags = fault;
      n.sel_f = i_target_sel;
      n.st = SD_ERR;
      n.reply = 1'b0;
      n.irq = r.irq | i_irq_en;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      r <= '{st: SD_CMD, sclk_s: 3'b000, cs_s: 3'b111, mosi_s: 2'b00,
             cko_s: 2'b00, rx: 16'h0000, tx: 16'h0000, bits: 4'h0,
             count: 5'd0, words: 5'd0, addr: 10'h000, rd: 1'b0,
             load: 1'b0, reply: 1'b0, flags: smon_pkg::FLAGS_RST,
             sel_f: 3'h0, irq: 1'b0, idle: 12'h000, wr_stb: 1'b0,
             wr_addr: 10'h000, wr_data: 16'h0000, rd_stb: 1'b0};
    end
    else
    begin
      r <= n;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign link.miso = r.tx[15];
  assign o_wr_stb = r.wr_stb;
  assign o_wr_addr = r.wr_addr;
  assign o_wr_data = r.wr_data;
  assign o_rd_stb = r.rd_stb;
  assign o_rd_addr = r.addr;
  assign o_fault_flags = r.flags;
  assign o_error_state = (r.st == SD_ERR);
  assign o_irq = r.irq;
endmodule : smon_dev
`default_nettype wire

// file: dv/smon_assertions.sv
`default_nettype none
module smon_assertions (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // link and status
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic i_cksys_ok,
  input wire logic i_irq_en,
  input wire logic [2:0] o_fault_flags,
  input wire logic o_error_state,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // ****************
  // link framing
  // ****************
  a_sclk_high_time: assert property (
    $rose(sclk) |=> sclk [*7]) else $error("sclk high too short");
  a_cs_setup: assert property (
    $fell(cs_n) |-> !sclk [*8]) else $error("sclk too soon after select");
  a_sclk_in_frame: assert property (
    $rose(sclk) |-> !cs_n) else $error("sclk edge outside frame");
  a_miso_steady: assert property (
    $rose(sclk) && !cs_n |-> $stable(miso) [*4])
    else $error("miso moved near sampling edge");
  // ****************
  // fault handling
  // ****************
  a_flags_freeze: assert property (
    o_fault_flags != 3'h0 |=> o_fault_flags == $past(o_fault_flags)
    || o_fault_flags == 3'h0) else $error("fault flags changed");
  a_fault_error: assert property (
    $rose(o_fault_flags != 3'h0) |-> ##[0:2] o_error_state)
    else $error("fault without error state");
  a_clock_absent: assert property (
    !cs_n && !i_cksys_ok && o_fault_flags == 3'h0 && !o_error_state
    |-> ##[1:6] o_fault_flags[2]) else $error("clock absent missed");
  a_irq_cause: assert property (
    $rose(o_irq) |-> o_fault_flags != 3'h0 && i_irq_en)
    else $error("irq without enabled fault");
  a_irq_follow: assert property (
    $rose(o_error_state) && i_irq_en |-> ##[0:2] o_irq)
    else $error("irq missing on fault");
  a_irq_drop: assert property (
    $fell(o_error_state) |-> ##[0:2] !o_irq) else $error("irq kept");
  a_flags_clear: assert property (
    $fell(o_fault_flags != 3'h0) |-> !cs_n) else $error("flags cleared idle");
endmodule : smon_assertions
`default_nettype wire

// file: dv/test_spi_slave_error_monitor.sv
`default_nettype none
module test_spi_slave_error_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cksys_ok = 1'b1;
  logic mode_gap = 1'b0;
  logic irq_en = 1'b1;
  logic [7:0] wdog = 8'h0a;
  logic [2:0] tsel = 3'h4;
  logic req = 1'b0;
  logic rcv = 1'b0;
  logic last = 1'b0;
  logic [15:0] word = 16'h0000;
  logic ready, rx_valid, wr_stb, err, irq;
  logic [15:0] rx_word, rd_data, wr_data, last_data;
  logic [9:0] rd_addr, wr_addr, last_addr;
  logic rd_stb;
  logic [2:0] flags, flags2;
  int error_cnt = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  smon_link_if link();
  smon_link_if link2();
  // ****************
  // design and checker
  // ****************
  // address-derived read data makes a wrong address visible
  assign rd_data = {6'h00, rd_addr} ^ 16'h5a00;
  smon_host i_smon_host (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .link(link), .i_req(req), .i_word(word), .i_recover(rcv),
    .i_last(last), .o_ready(ready), .o_rx_valid(rx_valid),
    .o_rx_word(rx_word));
  smon_dev i_smon_dev (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .link(link), .i_cksys_ok(cksys_ok), .i_mode_gap(mode_gap),
    .i_irq_en(irq_en), .i_wdog_limit(wdog), .i_target_sel(tsel),
    .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_rd_stb(rd_stb),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_fault_flags(flags),
    .o_error_state(err), .o_irq(irq));
  // second device end faces a bench driver that breaks word length
  smon_dev i_smon_dev_b (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .link(link2), .i_cksys_ok(cksys_ok), .i_mode_gap(mode_gap),
    .i_irq_en(irq_en), .i_wdog_limit(wdog), .i_target_sel(tsel),
    .o_wr_stb(), .o_wr_addr(), .o_wr_data(), .o_rd_stb(),
    .o_rd_addr(), .i_rd_data(rd_data), .o_fault_flags(flags2),
    .o_error_state(), .o_irq());
  smon_assertions i_smon_assertions (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .sclk(link.sclk), .cs_n(link.cs_n), .miso(link.miso),
    .i_cksys_ok(cksys_ok), .i_irq_en(irq_en), .o_fault_flags(flags),
    .o_error_state(err), .o_irq(irq));
  initial
  begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  // strobes are counted at the falling edge, away from their launch
  always @(negedge i_core_clk)
  begin
    if (wr_stb === 1'b1)
    begin
      wr_cnt++;
      last_addr = wr_addr;
      last_data = wr_data;
    end
    if (rd_stb === 1'b1)
      rd_cnt++;
  end
  // ****************
  // helpers
  // ****************
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : idle
  task automatic send(input logic [15:0] w, input logic rc,
    input logic lst, output logic [15:0] got);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 3000)
    begin
      @(negedge i_core_clk);
      n++;
    end
    word = w;
    rcv = rc;
    last = lst;
    req = 1'b1;
    @(negedge i_core_clk);
    req = 1'b0;
    while (rx_valid !== 1'b1 && n < 3000)
    begin
      @(negedge i_core_clk);
      n++;
    end
    if (n >= 3000)
    begin
      error_cnt++;
      $display("ERROR handshake expected 1 seen 0");
      report_and_stop;
    end
    got = rx_word;
  endtask : send
  // ****************
  // scenarios
  // ****************
  task automatic t_write(input logic [4:0] cnt, input int n);
    logic [15:0] r;
    int base;
    base = wr_cnt;
    send({1'b0, 10'h010, cnt}, 1'b0, 1'b0, r);
    chk("diag", {smon_pkg::DIAG_PATTERN, 3'h0}, r);
    for (int i = 0; i < n; i++)
    begin
      send(16'h1230 + 16'(i), 1'b0, i == n - 1, r);
      chk("diag", {smon_pkg::DIAG_PATTERN, 3'h0}, r);
    end
    idle(40);
    chk("writes", 16'(n), 16'(wr_cnt - base));
    chk("waddr", 16'h0010 + 16'(n - 1), {6'h00, last_addr});
    chk("wdata", 16'h1230 + 16'(n - 1), last_data);
    chk("flags", 16'h0000, 16'(flags));
  endtask : t_write
  task automatic t_read;
    logic [15:0] r;
    int base;
    base = rd_cnt;
    send({1'b1, 10'h020, 5'h01}, 1'b0, 1'b0, r);
    send(16'h0000, 1'b0, 1'b1, r);
    chk("rdata", 16'h5a20, r);
    idle(20);
    chk("reads", 16'h0001, 16'(rd_cnt - base));
  endtask : t_read
  task automatic t_frame;
    logic [15:0] r;
    int base;
    send({1'b0, 10'h010, 5'h02}, 1'b0, 1'b0, r);
    send(16'h0001, 1'b0, 1'b1, r);
    idle(40);
    chk("flags", 16'h0002, 16'(flags));
    chk("irq", 16'h0001, 16'(irq));
    base = wr_cnt;
    send({1'b0, 10'h010, 5'h01}, 1'b0, 1'b0, r);
    chk("diag", {smon_pkg::DIAG_PATTERN, 3'h2}, r);
    send(16'h0002, 1'b0, 1'b1, r);
    chk("writes", 16'h0000, 16'(wr_cnt - base));
    send(16'h0000, 1'b1, 1'b0, r);
    send(16'h0000, 1'b0, 1'b1, r);
    chk("reply", 16'h0002, r);
    idle(40);
    chk("flags", 16'h0000, 16'(flags));
    chk("err irq", 16'h0000, {14'h0000, err, irq});
  endtask : t_frame
  task automatic t_clock;
    logic [15:0] r;
    tsel = 3'h2;
    irq_en = 1'b0;
    cksys_ok = 1'b0;
    send({1'b0, 10'h010, 5'h01}, 1'b0, 1'b1, r);
    cksys_ok = 1'b1;
    idle(40);
    chk("flags", 16'h0004, 16'(flags));
    chk("irq", 16'h0000, 16'(irq));
    send(16'h0000, 1'b1, 1'b0, r);
    send(16'h0000, 1'b0, 1'b1, r);
    chk("reply", smon_pkg::ARB_REPLY, r);
    idle(40);
    chk("kept", 16'h0004, 16'(flags));
    chk("err", 16'h0000, 16'(err));
    send({1'b0, 10'h010, 5'h02}, 1'b0, 1'b0, r);
    send(16'h0001, 1'b0, 1'b1, r);
    idle(40);
    chk("frozen", 16'h0004, 16'(flags));
    send({1'b1, smon_pkg::FAULT_REG_OFS, 5'h01}, 1'b0, 1'b0, r);
    send(16'h0000, 1'b0, 1'b1, r);
    chk("code", 16'h0004, r);
    idle(40);
    chk("cleared", 16'h0000, 16'(flags));
    irq_en = 1'b1;
  endtask : t_clock
  task automatic t_bits;
    link2.mosi = 1'b0;
    link2.cs_n = 1'b0;
    idle(16);
    for (int i = 0; i < 31; i++)
    begin
      link2.sclk = 1'b1;
      idle(8);
      link2.sclk = 1'b0;
      idle(8);
      if (i == 20)
        chk("early", 16'h0000, 16'(flags2));
    end
    idle(16);
    link2.cs_n = 1'b1;
    link2.mosi = 1'b1;
    idle(20);
    chk("word flag", 16'h0001, 16'(flags2));
  endtask : t_bits
  task automatic t_gap;
    logic [15:0] r;
    mode_gap = 1'b1;
    send({1'b0, 10'h010, 5'h02}, 1'b0, 1'b1, r);
    send(16'h0001, 1'b0, 1'b1, r);
    idle(100);
    chk("gap ok", 16'h0000, 16'(flags));
    idle(100);
    chk("gap", 16'h0002, 16'(flags));
  endtask : t_gap
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    link2.sclk = 1'b0;
    link2.cs_n = 1'b1;
    link2.mosi = 1'b1;
    repeat (12) @(negedge i_core_clk);
    chk("reset flags", 16'h0000, 16'(flags));
    i_rst = 1'b0;
    t_write(5'h02, 2);
    t_write(5'h00, 3);
    t_read;
    t_frame;
    t_clock;
    t_bits;
    t_gap;
    report_and_stop;
  end
endmodule : test_spi_slave_error_monitor
`default_nettype wire
